// ### sbspc_bus_if.sv
`timescale 1ns/1ps
interface sbspc_bus_if;
  logic bus_init_n_o;
  logic bus_init_n_oe_n;
  logic block_next_req_n_o;
  logic block_next_req_n_oe_n;
  logic [5:0] brkpt_monitor_n_o;
  logic [5:0] brkpt_monitor_n_oe_n;
  logic probe_request_n_o;
  logic probe_request_n_oe_n;
  logic priority_bus_req_n;
  logic cen_bus_init_n_o;
  logic cen_bus_init_n_oe_n;
  logic cen_block_next_req_n_o;
  logic cen_block_next_req_n_oe_n;
  logic bus_init_n;
  logic block_next_req_n;
  logic [5:0] brkpt_monitor_n;

  // wired-or of active-low open-drain drivers
  assign bus_init_n = (bus_init_n_oe_n | bus_init_n_o) &
    (cen_bus_init_n_oe_n | cen_bus_init_n_o);
  assign block_next_req_n = (block_next_req_n_oe_n | block_next_req_n_o) &
    (cen_block_next_req_n_oe_n | cen_block_next_req_n_o);
  assign brkpt_monitor_n[3:0] = brkpt_monitor_n_oe_n[3:0] |
    brkpt_monitor_n_o[3:0];
  assign brkpt_monitor_n[4] = brkpt_monitor_n_oe_n[4] | brkpt_monitor_n_o[4];
  assign brkpt_monitor_n[5] = (brkpt_monitor_n_oe_n[5] |
    brkpt_monitor_n_o[5]) & (probe_request_n_oe_n | probe_request_n_o);

  modport dev (
    output bus_init_n_o, bus_init_n_oe_n,
    output block_next_req_n_o, block_next_req_n_oe_n,
    output brkpt_monitor_n_o, brkpt_monitor_n_oe_n,
    input bus_init_n, block_next_req_n, brkpt_monitor_n,
    input priority_bus_req_n
  );
  modport cen (
    output cen_bus_init_n_o, cen_bus_init_n_oe_n,
    output cen_block_next_req_n_o, cen_block_next_req_n_oe_n,
    output probe_request_n_o, probe_request_n_oe_n,
    output priority_bus_req_n,
    input bus_init_n, block_next_req_n, brkpt_monitor_n
  );
endinterface

// ### sbspc_central.sv
`timescale 1ns/1ps
module sbspc_central (
  input wire logic MCLK,
  input wire logic RST,
  sbspc_bus_if.cen BUS,
  input wire logic CFG_INIT_OBSERVE_EN,
  input wire logic ASSERT_INIT,
  input wire logic RX_BUSY,
  input wire logic PRI_PENDING,
  input wire logic DBG_REQ,
  output logic ERROR_EVENT,
  output logic PRI_OWNS,
  output logic [5:0] MONITOR,
  output logic PROBE_READY
);
  logic [1:0] init_sync_q, bnr_sync_q;
  logic [11:0] bpm_sync_q;
  logic [1:0] phase_q;
  logic bnr_drv_q, pri_q, init_q, probe_request_n_q;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      init_sync_q <= 2'h3;
      bnr_sync_q <= 2'h3;
      bpm_sync_q <= 12'hFFF;
      phase_q <= 2'h0;
    end else begin
      init_sync_q <= {init_sync_q[0], BUS.bus_init_n};
      bnr_sync_q <= {bnr_sync_q[0], BUS.block_next_req_n};
      bpm_sync_q <= {bpm_sync_q[5:0], BUS.brkpt_monitor_n};
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      bnr_drv_q <= 1'b0;
    end else if (phase_q == sbspc_pkg::BNR_DRIVE_PH) begin
      bnr_drv_q <= RX_BUSY;
    end
  end

  // hold priority until all own requests done
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pri_q <= 1'b0;
      init_q <= 1'b0;
      probe_request_n_q <= 1'b0;
      ERROR_EVENT <= 1'b0;
      MONITOR <= 6'h0;
      PROBE_READY <= 1'b0;
    end else begin
      pri_q <= PRI_PENDING;
      init_q <= ASSERT_INIT;
      probe_request_n_q <= DBG_REQ;
      ERROR_EVENT <= !CFG_INIT_OBSERVE_EN && !init_sync_q[1];
      MONITOR <= ~bpm_sync_q[11:6];
      PROBE_READY <= !bpm_sync_q[6 + sbspc_pkg::BPM_PROBE_READY_N];
    end
  end

  assign PRI_OWNS = pri_q;
  assign BUS.priority_bus_req_n = !pri_q;
  assign BUS.cen_bus_init_n_o = 1'b0;
  assign BUS.cen_bus_init_n_oe_n = !init_q;
  assign BUS.cen_block_next_req_n_o = 1'b0;
  assign BUS.cen_block_next_req_n_oe_n = !bnr_drv_q;
  assign BUS.probe_request_n_o = 1'b0;
  assign BUS.probe_request_n_oe_n = !probe_request_n_q;
endmodule

// ### sbspc_device.sv
`timescale 1ns/1ps
// Behaviour
// - drive bus init on fatal bus condition
// - bus init resets lock and arbitration
// - bus init keeps queue and tracking
// - after bus init rearbitrate, finish queues
// - init observation off: central agent decides
// - busy agent asserts block next request
// - no new transaction during stall
// - wire-or stall driven, sampled on phases
// - six monitor lines; bits 3:0 show breakpoints, perf counter bit 5 not driven
// - monitor bit 4 is probe ready
// - debug tool requests via monitor bit 5
// - priority request stops non-locked requests
// - priority agent holds until done
// - everything timed on bus clock
module sbspc_device (
  input wire logic MCLK,
  input wire logic RST,
  sbspc_bus_if.dev BUS,
  input wire logic CFG_INIT_DRIVE_EN,
  input wire logic CFG_INIT_OBSERVE_EN,
  input wire logic BUS_FAULT,
  input wire logic RX_BUSY,
  input wire logic TX_PENDING,
  input wire logic TX_LOCKED,
  input wire logic [3:0] BRKPT_HIT,
  input wire logic PERF_EVENT,
  input wire logic DEBUG_READY,
  output logic TX_ISSUE,
  output logic OWNS_BUS,
  output logic LOCK_ACTIVE,
  output logic PROBE_REQ,
  output logic INIT_SEEN,
  output logic QUEUE_KEPT
);
  logic drive_en_q, observe_en_q;
  logic [1:0] init_sync_q, bnr_sync_q, pri_sync_q, probe_request_n_sync_q;
  logic init_in, stall_in, pri_in;
  logic [1:0] phase_q;
  logic stall_q;
  logic bnr_drv_q;
  logic init_drv_q;
  logic lock_q;
  logic [3:0] retry_q;
  logic [5:0] bpm_q;
  logic init_seen_q;
  sbspc_pkg::sbspc_arb_e arb_q;

  // straps caught whenever arbitration idle and no bus init seen
  always_ff @(posedge MCLK) begin
    if (RST) begin
      drive_en_q <= 1'b0;
      observe_en_q <= 1'b0;
    end else if (arb_q == sbspc_pkg::SBSPC_IDLE && !init_seen_q) begin
      drive_en_q <= CFG_INIT_DRIVE_EN;
      observe_en_q <= CFG_INIT_OBSERVE_EN;
    end
  end

  // two-flop input synchronisers, all on bus clock
  always_ff @(posedge MCLK) begin
    if (RST) begin
      init_sync_q <= 2'h3;
      bnr_sync_q <= 2'h3;
      pri_sync_q <= 2'h3;
      probe_request_n_sync_q <= 2'h3;
    end else begin
      init_sync_q <= {init_sync_q[0], BUS.bus_init_n};
      bnr_sync_q <= {bnr_sync_q[0], BUS.block_next_req_n};
      pri_sync_q <= {pri_sync_q[0], BUS.priority_bus_req_n};
      probe_request_n_sync_q <= {probe_request_n_sync_q[0],
        BUS.brkpt_monitor_n[sbspc_pkg::BPM_PROBE_REQUEST_N]};
    end
  end

  assign init_in = !init_sync_q[1];
  assign stall_in = !bnr_sync_q[1];
  assign pri_in = !pri_sync_q[1];

  always_ff @(posedge MCLK) begin
    if (RST) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // stall driven and sampled only on fixed phases
  always_ff @(posedge MCLK) begin
    if (RST) begin
      bnr_drv_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      if (phase_q == sbspc_pkg::BNR_DRIVE_PH) begin
        bnr_drv_q <= RX_BUSY;
      end
      if (phase_q == sbspc_pkg::BNR_SAMPLE_PH) begin
        stall_q <= stall_in;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      init_drv_q <= 1'b0;
    end else begin
      init_drv_q <= drive_en_q && BUS_FAULT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      init_seen_q <= 1'b0;
    end else if (observe_en_q && init_in) begin
      init_seen_q <= 1'b1;
    end else if (arb_q == sbspc_pkg::SBSPC_OWN) begin
      init_seen_q <= 1'b0;
    end
  end

  // lock tracking cleared by observed bus init
  always_ff @(posedge MCLK) begin
    if (RST) begin
      lock_q <= 1'b0;
    end else if (observe_en_q && init_in) begin
      lock_q <= 1'b0;
    end else if (arb_q == sbspc_pkg::SBSPC_OWN && TX_ISSUE) begin
      lock_q <= TX_LOCKED;
    end else if (!TX_PENDING) begin
      lock_q <= 1'b0;
    end
  end

  // arbitration machine; pending queue lives outside and is untouched
  always_ff @(posedge MCLK) begin
    if (RST) begin
      arb_q <= sbspc_pkg::SBSPC_IDLE;
      retry_q <= 4'h0;
    end else if (observe_en_q && init_in) begin
      arb_q <= sbspc_pkg::SBSPC_RECOVER;
      retry_q <= sbspc_pkg::RETRY_GAP;
    end else begin
      case (arb_q)
        sbspc_pkg::SBSPC_IDLE: begin
          if (TX_PENDING) begin
            arb_q <= sbspc_pkg::SBSPC_REQ;
          end
        end
        sbspc_pkg::SBSPC_REQ: begin
          if (!pri_in || lock_q) begin
            arb_q <= sbspc_pkg::SBSPC_OWN;
          end
        end
        sbspc_pkg::SBSPC_OWN: begin
          if (!TX_PENDING) begin
            arb_q <= sbspc_pkg::SBSPC_IDLE;
          end else if (pri_in && !lock_q) begin
            arb_q <= sbspc_pkg::SBSPC_REQ;
          end
        end
        sbspc_pkg::SBSPC_RECOVER: begin
          if (retry_q != 4'h0) begin
            retry_q <= retry_q - 4'h1;
          end else begin
            arb_q <= sbspc_pkg::SBSPC_IDLE;
          end
        end
        default: begin
          arb_q <= sbspc_pkg::SBSPC_IDLE;
        end
      endcase
    end
  end

  // issue only as owner, no stall, no priority unless locked
  always_comb begin
    TX_ISSUE = arb_q == sbspc_pkg::SBSPC_OWN && TX_PENDING &&
      !stall_q &&
      (!pri_in || lock_q) && !(observe_en_q && init_in);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      bpm_q <= 6'h0;
    end else begin
      bpm_q[3:0] <= BRKPT_HIT;
      bpm_q[sbspc_pkg::BPM_PROBE_READY_N] <= DEBUG_READY;
      bpm_q[sbspc_pkg::BPM_PROBE_REQUEST_N] <= PERF_EVENT;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      PROBE_REQ <= 1'b0;
    end else begin
      PROBE_REQ <= !probe_request_n_sync_q[1];
    end
  end

  assign OWNS_BUS = arb_q == sbspc_pkg::SBSPC_OWN;
  assign LOCK_ACTIVE = lock_q;
  assign INIT_SEEN = init_seen_q;
  assign QUEUE_KEPT = TX_PENDING;

  // open-drain: low enable drives low
  assign BUS.bus_init_n_o = 1'b0;
  assign BUS.bus_init_n_oe_n = !init_drv_q;
  assign BUS.block_next_req_n_o = 1'b0;
  assign BUS.block_next_req_n_oe_n = !bnr_drv_q;
  assign BUS.brkpt_monitor_n_o = 6'h0;
  // bit 5 shared with probe request: device never drives it
  assign BUS.brkpt_monitor_n_oe_n = {1'b1, ~bpm_q[4:0]};
endmodule

// ### sbspc_monitor.sv
`timescale 1ns/1ps
module sbspc_monitor (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic bus_init_n_o,
  input wire logic bus_init_n_oe_n,
  input wire logic cen_bus_init_n_oe_n,
  input wire logic block_next_req_n_o,
  input wire logic block_next_req_n_oe_n,
  input wire logic cen_block_next_req_n_oe_n,
  input wire logic [5:0] brkpt_monitor_n_oe_n,
  input wire logic bus_init_n,
  input wire logic block_next_req_n,
  input wire logic [5:0] brkpt_monitor_n,
  input wire logic priority_bus_req_n
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_reset_lines_idle: assert property (
    $past(RST) |-> bus_init_n && block_next_req_n && priority_bus_req_n)
    else $error("line asserted right after reset");
  a_init_drive_low: assert property (
    !bus_init_n_oe_n |-> !bus_init_n_o)
    else $error("bus init driver not low");
  a_stall_drive_low: assert property (
    !block_next_req_n_oe_n |-> !block_next_req_n_o)
    else $error("stall driver not low");
  a_bit5_not_driven: assert property (
    brkpt_monitor_n_oe_n[5])
    else $error("device drives probe request bit");
  a_dev_stall_phase: assert property (
    $changed(block_next_req_n_oe_n) |=>
      $stable(block_next_req_n_oe_n)[*3])
    else $error("device stall drive off its phase");
  a_cen_stall_phase: assert property (
    $changed(cen_block_next_req_n_oe_n) |=>
      $stable(cen_block_next_req_n_oe_n)[*3])
    else $error("central stall drive off its phase");
  a_init_has_driver: assert property (
    !bus_init_n |-> !bus_init_n_oe_n || !cen_bus_init_n_oe_n)
    else $error("bus init low with no driver");
  a_stall_has_driver: assert property (
    !block_next_req_n |->
      !block_next_req_n_oe_n || !cen_block_next_req_n_oe_n)
    else $error("stall low with no driver");
  a_probe_ready_src: assert property (
    !brkpt_monitor_n[4] |-> !brkpt_monitor_n_oe_n[4])
    else $error("probe ready low with no driver");

  c_init: cover property (!bus_init_n);
  c_stall: cover property (!block_next_req_n);
  c_priority: cover property (!priority_bus_req_n);
endmodule

// ### sbspc_pkg.sv
package sbspc_pkg;
  localparam int BPM_W = 6;
  localparam int BPM_PROBE_READY_N = 4;
  localparam int BPM_PROBE_REQUEST_N = 5;
  localparam int BNR_PHASE_W = 2;
  localparam logic [1:0] BNR_DRIVE_PH = 2'h0;
  localparam logic [1:0] BNR_SAMPLE_PH = 2'h2;
  localparam logic [1:0] BNR_PH_LAST = 2'h3;
  localparam int RETRY_W = 4;
  localparam logic [3:0] RETRY_GAP = 4'h4;

  typedef enum logic [3:0] {
    SBSPC_IDLE = 4'h1,
    SBSPC_REQ = 4'h2,
    SBSPC_OWN = 4'h4,
    SBSPC_RECOVER = 4'h8
  } sbspc_arb_e;
endpackage

// ### tb_system_bus_stall_priority_ctrl.sv
`timescale 1ns/1ps
module tb_system_bus_stall_priority_ctrl;
  typedef struct packed {logic [3:0] b; logic r; logic [4:0] w;} sbspc_row_s;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cfg_drv = 1'b1, cfg_obs = 1'b1, c_obs = 1'b1, fault = 1'b0;
  logic d_busy = 1'b0, pend = 1'b0, locked = 1'b0, perf = 1'b0;
  logic dbg_rdy = 1'b0, a_init = 1'b0, c_busy = 1'b0, pri = 1'b0;
  logic dbg_req = 1'b0;
  logic [3:0] brk = 4'h0;
  logic tx_issue, owns, lock_act, probe_req, init_seen, q_kept;
  logic err_ev, pri_owns, p_rdy;
  logic [5:0] mon;
  int fail_count = 0;
  int checks = 0;
  sbspc_row_s rows [4] = '{{4'h0, 1'b0, 5'h1F}, {4'h5, 1'b1, 5'h0A},
    {4'hA, 1'b0, 5'h15}, {4'hF, 1'b1, 5'h00}};

  sbspc_bus_if bus ();
  sbspc_device u_sbspc_device (.MCLK(mclk), .RST(rst), .BUS(bus.dev),
    .CFG_INIT_DRIVE_EN(cfg_drv), .CFG_INIT_OBSERVE_EN(cfg_obs),
    .BUS_FAULT(fault), .RX_BUSY(d_busy), .TX_PENDING(pend),
    .TX_LOCKED(locked), .BRKPT_HIT(brk), .PERF_EVENT(perf),
    .DEBUG_READY(dbg_rdy), .TX_ISSUE(tx_issue), .OWNS_BUS(owns),
    .LOCK_ACTIVE(lock_act), .PROBE_REQ(probe_req),
    .INIT_SEEN(init_seen), .QUEUE_KEPT(q_kept));
  sbspc_central u_sbspc_central (.MCLK(mclk), .RST(rst), .BUS(bus.cen),
    .CFG_INIT_OBSERVE_EN(c_obs), .ASSERT_INIT(a_init), .RX_BUSY(c_busy),
    .PRI_PENDING(pri), .DBG_REQ(dbg_req), .ERROR_EVENT(err_ev),
    .PRI_OWNS(pri_owns), .MONITOR(mon), .PROBE_READY(p_rdy));
  sbspc_monitor u_sbspc_monitor (.MCLK(mclk), .RST(rst),
    .bus_init_n_o(bus.bus_init_n_o), .bus_init_n_oe_n(bus.bus_init_n_oe_n),
    .cen_bus_init_n_oe_n(bus.cen_bus_init_n_oe_n),
    .block_next_req_n_o(bus.block_next_req_n_o),
    .block_next_req_n_oe_n(bus.block_next_req_n_oe_n),
    .cen_block_next_req_n_oe_n(bus.cen_block_next_req_n_oe_n),
    .brkpt_monitor_n_oe_n(bus.brkpt_monitor_n_oe_n),
    .bus_init_n(bus.bus_init_n), .block_next_req_n(bus.block_next_req_n),
    .brkpt_monitor_n(bus.brkpt_monitor_n),
    .priority_bus_req_n(bus.priority_bus_req_n));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fail_count++;
    stop_test();
  end

  initial begin
    settle(16);
    rst = 1'b0;
    settle(1);
    chk_vec(bus.brkpt_monitor_n, 6'h3F);
    chk_vec({3'h0, bus.bus_init_n, bus.block_next_req_n,
      bus.priority_bus_req_n}, 6'h07);
    $display("test reset done");
    foreach (rows[i]) begin
      brk = rows[i].b;
      dbg_rdy = rows[i].r;
      settle(8);
      chk_vec({1'b0, bus.brkpt_monitor_n[4:0]}, {1'b0, rows[i].w});
      chk_vec({1'b0, mon[4:0]}, {1'b0, ~rows[i].w});
      chk_bit(p_rdy, rows[i].r);
    end
    $display("test monitor rows done");
    dbg_req = 1'b1;
    settle(8);
    chk_bit(probe_req, 1'b1);
    chk_bit(bus.brkpt_monitor_n[5], 1'b0);
    dbg_req = 1'b0;
    $display("test probe request done");
    c_busy = 1'b1;
    pend = 1'b1;
    settle(10);
    chk_bit(bus.block_next_req_n, 1'b0);
    chk_bit(tx_issue, 1'b0);
    c_busy = 1'b0;
    d_busy = 1'b1;
    settle(10);
    chk_bit(bus.block_next_req_n, 1'b0);
    chk_bit(tx_issue, 1'b0);
    d_busy = 1'b0;
    settle(12);
    chk_bit(bus.block_next_req_n, 1'b1);
    chk_bit(tx_issue, 1'b1);
    chk_bit(owns, 1'b1);
    $display("test stall done");
    pri = 1'b1;
    settle(1);
    chk_bit(bus.priority_bus_req_n, 1'b0);
    settle(8);
    chk_bit(tx_issue, 1'b0);
    chk_bit(pri_owns, 1'b1);
    pri = 1'b0;
    settle(12);
    chk_bit(bus.priority_bus_req_n, 1'b1);
    chk_bit(tx_issue, 1'b1);
    $display("test priority done");
    locked = 1'b1;
    settle(2);
    chk_bit(lock_act, 1'b1);
    pri = 1'b1;
    settle(8);
    chk_bit(tx_issue, 1'b1);
    chk_bit(owns, 1'b1);
    $display("test locked priority done");
    a_init = 1'b1;
    settle(6);
    chk_bit(init_seen, 1'b1);
    chk_bit(lock_act, 1'b0);
    chk_bit(q_kept, 1'b1);
    chk_bit(tx_issue, 1'b0);
    a_init = 1'b0;
    pri = 1'b0;
    locked = 1'b0;
    settle(20);
    chk_bit(tx_issue, 1'b1);
    $display("test bus init observe done");
    pend = 1'b0;
    c_obs = 1'b0;
    settle(4);
    fault = 1'b1;
    settle(6);
    chk_bit(bus.bus_init_n, 1'b0);
    chk_bit(err_ev, 1'b1);
    fault = 1'b0;
    settle(20);
    $display("test bus fault done");
    rst = 1'b1;
    cfg_drv = 1'b0;
    cfg_obs = 1'b0;
    settle(4);
    rst = 1'b0;
    settle(1);
    chk_bit(init_seen, 1'b0);
    chk_bit(owns, 1'b0);
    fault = 1'b1;
    a_init = 1'b1;
    settle(6);
    chk_bit(bus.bus_init_n_oe_n, 1'b1);
    chk_bit(bus.bus_init_n, 1'b0);
    chk_bit(init_seen, 1'b0);
    chk_bit(err_ev, 1'b1);
    fault = 1'b0;
    a_init = 1'b0;
    settle(8);
    chk_bit(err_ev, 1'b0);
    $display("test straps off after reset done");
    stop_test();
  end
endmodule
